// >>> clk_select_defs.svh
`ifndef CLK_SELECT_DEFS_SVH
`define CLK_SELECT_DEFS_SVH

// AXI4-Lite byte offsets
`define ADDR_SOURCE_SELECT 4'h0
`define ADDR_OSC_CONTROL   4'h4
`define ADDR_CLOCK_CONTROL 4'h8
`define ADDR_STATUS        4'hc

// Field positions
`define BIT_SELECT       0
`define BIT_PRI_ENABLE   0
`define BIT_SEC_ENABLE   1
`define BIT_UNDIVIDED    0
`define LSB_RELOAD       8
`define LSB_PERIPH       16

// Fuse source codes
`define PRI_HS_CRYSTAL 2'h3
`define PRI_LP_CRYSTAL 2'h2
`define SRC_EXTERNAL   2'h1
`define SRC_RC         2'h0

// Reset values and the new-source edge count that ends a switch
`define RELOAD_RESET  8'hff
`define PERIPH_RESET  4'h0
`define SYNC_DONE     2'h2

// Startup waits in reference cycles per source kind
`define WAIT_CRYSTAL  16'h4000
`define WAIT_EXTERNAL 16'h0010
`define WAIT_RC       16'h0040

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> clk_select_pkg.sv
package clk_select_pkg;
	typedef struct packed {
		logic [3:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [3:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_t;

	typedef struct packed {
		logic [1:0] primary_source;
		logic [1:0] secondary_source;
		logic       oscillator_select_fuse;
		logic       undivided_default;
		logic [7:0] user_calibration;
		logic [7:0] factory_calibration;
	} fuse_t;

	// Pad owner per pin: 1 = pin free as port, 0 = taken by oscillator; amp bits: 1 = amplifier on
	typedef struct packed {
		logic port4_pin6_free;
		logic port4_pin7_free;
		logic port1_pin0_free;
		logic port4_pin2_free;
		logic primary_amp_on;
		logic secondary_amp_on;
	} pad_ctrl_t;
endpackage

// >>> clk_select.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`include "clk_select_defs.svh"

module dual_oscillator_clock_select #(
	parameter int RELOAD_WIDTH = 8,
	parameter int PERIPH_WIDTH = 4
) (
	input  wire logic                     i_clock,       // Reference clock, 125 MHz
	input  wire logic                     i_arst_n,      // Async reset, active low
	input  wire logic                     i_enable,      // Clock enable
	input  wire clk_select_pkg::fuse_t    i_fuse,        // Fuse settings
	input  wire logic                     i_primary_osc, // Primary slot oscillator, sampled
	input  wire logic                     i_secondary_osc, // Secondary slot oscillator
	input  wire clk_select_pkg::axil_req_t i_axil,       // AXI4-Lite request
	output clk_select_pkg::axil_rsp_t     o_axil,        // AXI4-Lite response
	output logic                          o_sys_clock,   // System clock enable pulse
	output logic                          o_periph_tick, // Peripheral clock enable pulse
	output logic                          o_startup_done, // Startup wait elapsed
	output clk_select_pkg::pad_ctrl_t     o_pads,        // Pad ownership
	output logic [7:0]                    o_rc_trim      // RC trim code
);
	import clk_select_pkg::*;

	// Counters and field slices are written for the documented widths only
	if (RELOAD_WIDTH != 8 || PERIPH_WIDTH != 4) begin : g_bad_width
		$error("unsupported divider widths");
	end

	typedef enum logic [1:0] {
		sw_run  = 2'b00,
		sw_stop = 2'b01,
		sw_wait = 2'b10
	} switch_state_t;

	typedef struct packed {
		logic                    fuse_loaded;
		logic                    select;
		logic                    pri_en;
		logic                    sec_en;
		logic                    pending;
		switch_state_t           sw;
		logic [1:0]              edge_cnt;
		logic [1:0]              pri_hist;
		logic [1:0]              sec_hist;
		logic                    active;
		logic                    undivided;
		logic                    half;
		logic [RELOAD_WIDTH-1:0] reload;
		logic [RELOAD_WIDTH-1:0] presc;
		logic [PERIPH_WIDTH-1:0] periph_div;
		logic [PERIPH_WIDTH-1:0] periph_cnt;
		logic [15:0]             wait_cnt;
		logic                    started;
		logic                    sys;
		logic                    ptick;
		logic                    aw_got;
		logic [3:0]              aw_addr;
		logic                    w_got;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} state_t;

	state_t st;
	state_t next_st;

	logic pri_edge;
	logic sec_edge;
	logic new_edge;
	logic src_edge;
	logic wr_fire;
	logic [31:0] rd_word;

	always_comb begin
		pri_edge = st.pri_hist == 2'b01;
		sec_edge = st.sec_hist == 2'b01;
		new_edge = st.pending ? pri_edge : sec_edge;
		src_edge = st.active ? pri_edge : sec_edge;
		wr_fire  = st.aw_got && st.w_got && !st.bvalid;
		case (i_axil.araddr)
			`ADDR_SOURCE_SELECT: rd_word = {31'h0, st.select};
			`ADDR_OSC_CONTROL:   rd_word = {30'h0, st.sec_en, st.pri_en};
			`ADDR_CLOCK_CONTROL: rd_word = {12'h0, st.periph_div, st.reload, 7'h0,
				st.undivided};
			`ADDR_STATUS:        rd_word = {29'h0, st.started, st.sw != sw_run, st.active};
			default:             rd_word = 32'h0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.sys = 1'b0;
		next_st.ptick = 1'b0;
		next_st.pri_hist = {st.pri_hist[0], i_primary_osc && st.pri_en};
		next_st.sec_hist = {st.sec_hist[0], i_secondary_osc && st.sec_en};

		if (!st.fuse_loaded) begin
			next_st.fuse_loaded = 1'b1;
			next_st.select    = i_fuse.oscillator_select_fuse;
			next_st.active    = i_fuse.oscillator_select_fuse;
			next_st.pri_en    = i_fuse.oscillator_select_fuse;
			next_st.sec_en    = !i_fuse.oscillator_select_fuse;
			next_st.undivided = i_fuse.undivided_default;
			case (i_fuse.oscillator_select_fuse ? i_fuse.primary_source :
				(i_fuse.secondary_source[1] ? `PRI_LP_CRYSTAL : i_fuse.secondary_source))
				`PRI_HS_CRYSTAL, `PRI_LP_CRYSTAL: next_st.wait_cnt = `WAIT_CRYSTAL;
				`SRC_EXTERNAL: next_st.wait_cnt = `WAIT_EXTERNAL;
				default:       next_st.wait_cnt = `WAIT_RC;
			endcase
		end else if (!st.started) begin
			if (st.wait_cnt == 16'h0)
				next_st.started = 1'b1;
			else
				next_st.wait_cnt = st.wait_cnt - 16'h1;
		end

		// Glitch-free hand-over: stop on an old edge, resume on the second edge of the new one
		case (st.sw)
			sw_run: begin
				if (st.select != st.active) begin
					next_st.sw = sw_stop;
					next_st.pending = st.select;
					next_st.edge_cnt = 2'h0;
				end
			end
			sw_stop: begin
				if (src_edge || !(st.active ? st.pri_en : st.sec_en)) begin
					next_st.sw = sw_wait;
					next_st.edge_cnt = 2'h0;
				end
			end
			sw_wait: begin
				if (new_edge) begin
					next_st.edge_cnt = st.edge_cnt + 2'h1;
					if (st.edge_cnt + 2'h1 == `SYNC_DONE) begin
						next_st.active = st.pending;
						next_st.sw = sw_run;
					end
				end
			end
			default: next_st.sw = sw_run;
		endcase

		// Divide stage then reload prescaler, shared by both slots
		if (st.started && st.sw == sw_run && src_edge) begin
			next_st.half = !st.half;
			if (st.undivided || st.half) begin
				if (st.reload == `RELOAD_RESET) begin
					next_st.sys = 1'b1;
				end else if (st.presc == `RELOAD_RESET) begin
					next_st.presc = st.reload;
					next_st.sys = 1'b1;
				end else begin
					next_st.presc = st.presc + 8'h1;
				end
			end
		end
		if (st.sys) begin
			if (st.periph_cnt >= st.periph_div) begin
				next_st.periph_cnt = `PERIPH_RESET;
				next_st.ptick = 1'b1;
			end else begin
				next_st.periph_cnt = st.periph_cnt + 4'h1;
			end
		end

		// AXI4-Lite slave
		if (i_axil.awvalid && !st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = i_axil.awaddr;
		end
		if (i_axil.wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.w_data = i_axil.wdata;
			// Strobes are kept with the data: the master may drop them once taken
			next_st.w_strb = i_axil.wstrb;
		end
		if (wr_fire) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `RESP_OKAY;
			case (st.aw_addr)
				`ADDR_SOURCE_SELECT: begin
					if (st.w_strb[0]) begin
						if (st.w_data[`BIT_SELECT] ? st.pri_en : st.sec_en)
							next_st.select = st.w_data[`BIT_SELECT];
					end
				end
				`ADDR_OSC_CONTROL: begin
					if (st.w_strb[0]) begin
						next_st.pri_en = st.w_data[`BIT_PRI_ENABLE] || st.select;
						next_st.sec_en = st.w_data[`BIT_SEC_ENABLE] || !st.select;
					end
				end
				`ADDR_CLOCK_CONTROL: begin
					if (st.w_strb[0])
						next_st.undivided = st.w_data[`BIT_UNDIVIDED];
					if (st.w_strb[1])
						next_st.reload = st.w_data[`LSB_RELOAD +: 8];
					if (st.w_strb[2])
						next_st.periph_div = st.w_data[`LSB_PERIPH +: 4];
				end
				`ADDR_STATUS: ;
				default: next_st.bresp = `RESP_SLVERR;
			endcase
		end
		if (st.bvalid && i_axil.bready)
			next_st.bvalid = 1'b0;
		if (i_axil.arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = (i_axil.araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (st.rvalid && i_axil.rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
			st.select <= 1'b1;
			st.active <= 1'b1;
			st.pri_en <= 1'b1;
			st.reload <= `RELOAD_RESET;
			st.presc <= `RELOAD_RESET;
		end else if (i_enable) begin
			st <= next_st;
		end
	end

	always_comb begin
		o_axil.awready = !st.aw_got;
		o_axil.wready  = !st.w_got;
		o_axil.bvalid  = st.bvalid;
		o_axil.bresp   = st.bresp;
		o_axil.arready = !st.rvalid;
		o_axil.rvalid  = st.rvalid;
		o_axil.rdata   = st.rdata;
		o_axil.rresp   = st.rresp;
		o_sys_clock    = st.sys;
		o_periph_tick  = st.ptick;
		o_startup_done = st.started;
		// Crystal holds both pads; external holds input only; RC frees both
		o_pads.port4_pin6_free = !st.pri_en || i_fuse.primary_source == `SRC_RC;
		o_pads.port4_pin7_free = !st.pri_en || !i_fuse.primary_source[1];
		o_pads.primary_amp_on  = st.pri_en && i_fuse.primary_source[1];
		o_pads.port1_pin0_free = !st.sec_en || (!i_fuse.secondary_source[1] &&
			!i_fuse.secondary_source[0]);
		o_pads.port4_pin2_free = !st.sec_en || !i_fuse.secondary_source[1];
		o_pads.secondary_amp_on = st.sec_en && i_fuse.secondary_source[1];
		// User byte trims; factory copy stays untouched on its own input
		o_rc_trim = i_fuse.user_calibration;
	end
endmodule // dual_oscillator_clock_select

// >>> dual_osc_sel_checker.sv
`include "clk_select_defs.svh"
module dual_osc_sel_checker import clk_select_pkg::*; (
	input wire logic                      i_clock,        // Clock
	input wire logic                      i_arst_n,       // Reset
	input wire clk_select_pkg::fuse_t     i_fuse,         // Fuses
	input wire clk_select_pkg::pad_ctrl_t o_pads,         // Pads
	input wire logic [7:0]                o_rc_trim,      // Trim
	input wire logic                      o_startup_done  // Started
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	property p_trim; o_rc_trim == i_fuse.user_calibration; endproperty
	a_trim: assert property (p_trim) else $error("trim not from calibration byte");
	property p_pri_xtal;
		i_fuse.primary_source[1] && o_pads.primary_amp_on |->
			!o_pads.port4_pin6_free && !o_pads.port4_pin7_free;
	endproperty
	a_pri_xtal: assert property (p_pri_xtal) else $error("primary crystal pins free");
	property p_pri_ext;
		i_fuse.primary_source == `SRC_EXTERNAL |-> !o_pads.primary_amp_on && o_pads.port4_pin7_free;
	endproperty
	a_pri_ext: assert property (p_pri_ext) else $error("primary external pads wrong");
	property p_pri_rc;
		i_fuse.primary_source == `SRC_RC |-> o_pads.port4_pin6_free && o_pads.port4_pin7_free;
	endproperty
	a_pri_rc: assert property (p_pri_rc) else $error("primary rc pads not free");
	property p_sec_xtal;
		i_fuse.secondary_source[1] && o_pads.secondary_amp_on |->
			!o_pads.port1_pin0_free && !o_pads.port4_pin2_free;
	endproperty
	a_sec_xtal: assert property (p_sec_xtal) else $error("secondary crystal pins free");
	property p_sec_ext;
		i_fuse.secondary_source == `SRC_EXTERNAL |-> !o_pads.secondary_amp_on && o_pads.port4_pin2_free;
	endproperty
	a_sec_ext: assert property (p_sec_ext) else $error("secondary external pads wrong");
	property p_sec_rc;
		i_fuse.secondary_source == `SRC_RC |-> o_pads.port1_pin0_free && o_pads.port4_pin2_free;
	endproperty
	a_sec_rc: assert property (p_sec_rc) else $error("secondary rc pads not free");
	// Shortest wait is sixteen cycles, so eight is a safe floor
	property p_start; $rose(i_arst_n) |-> !o_startup_done [*8]; endproperty
	a_start: assert property (p_start) else $error("startup wait too short");
endmodule // dual_osc_sel_checker
bind dual_oscillator_clock_select dual_osc_sel_checker u_chk (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_fuse(i_fuse), .o_pads(o_pads),
	.o_rc_trim(o_rc_trim), .o_startup_done(o_startup_done));

// >>> dual_oscillator_clock_select_tb_top.sv
`include "clk_select_defs.svh"
module dual_oscillator_clock_select_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import clk_select_pkg::*;
	logic       i_clock = 0, i_arst_n = 0, i_primary_osc = 0, i_secondary_osc = 0;
	fuse_t      i_fuse = '0;
	axil_req_t  rq = '0;
	axil_rsp_t  rs;
	pad_ctrl_t  o_pads;
	logic       o_sys_clock, o_periph_tick, o_startup_done;
	logic [7:0] o_rc_trim;
	logic [31:0] rd;
	logic [1:0] rr;
	int         miscompares = 0, checks_done = 0, pc = 0, sc = 0, cyc = 0;
	initial forever #4 i_clock = ~i_clock;
	// Two toggles of the 3- and 5-cycle counters below
	localparam int PRI_PERIOD = 6;
	localparam int SEC_PERIOD = 10;
	// Oscillators well below half the reference rate so sampling sees every edge
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		pc <= (pc == 2) ? 0 : pc + 1;
		sc <= (sc == 4) ? 0 : sc + 1;
		if (pc == 2) i_primary_osc <= ~i_primary_osc;
		if (sc == 4) i_secondary_osc <= ~i_secondary_osc;
	end
	dual_oscillator_clock_select u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_enable(1'b1),
		.i_fuse(i_fuse), .i_primary_osc(i_primary_osc), .i_secondary_osc(i_secondary_osc),
		.i_axil(rq), .o_axil(rs), .o_sys_clock(o_sys_clock), .o_periph_tick(o_periph_tick),
		.o_startup_done(o_startup_done), .o_pads(o_pads), .o_rc_trim(o_rc_trim));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Handshakes are judged at the falling edge, where inputs and readies are settled
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bit ta, tw, tb;
		@(posedge i_clock);
		rq.awaddr <= a;
		rq.awvalid <= 1'b1;
		rq.wdata <= d;
		rq.wstrb <= 4'hf;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		forever begin
			@(negedge i_clock);
			ta = rq.awvalid && rs.awready;
			tw = rq.wvalid && rs.wready;
			tb = rs.bvalid;
			rr = rs.bresp;
			@(posedge i_clock);
			if (ta) rq.awvalid <= 1'b0;
			if (tw) rq.wvalid <= 1'b0;
			if (tb) begin
				rq.bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rdt(input logic [3:0] a);
		bit ta, tr;
		@(posedge i_clock);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		forever begin
			@(negedge i_clock);
			ta = rq.arvalid && rs.arready;
			tr = rs.rvalid;
			rd = rs.rdata;
			rr = rs.rresp;
			@(posedge i_clock);
			if (ta) rq.arvalid <= 1'b0;
			if (tr) begin
				rq.rready <= 1'b0;
				break;
			end
		end
	endtask
	// Gap between the second and third pulse, after any change has settled
	task automatic gap(input bit tick, output int g);
		int c0;
		repeat (2) begin
			do @(negedge i_clock); while (!(tick ? o_periph_tick : o_sys_clock));
		end
		c0 = cyc;
		do @(negedge i_clock); while (!(tick ? o_periph_tick : o_sys_clock));
		g = cyc - c0;
	endtask
	// Divide stage, then reload count up to ff, then peripheral count
	function automatic int exp_gap(int period, bit undiv, logic [7:0] rl, logic [3:0] pd);
		return period * (undiv ? 1 : 2) * (256 - rl) * (pd + 1);
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		fuse_t f;
		bit sel;
		int n;
		logic [31:0] d;
		logic [7:0] rl;
		logic [3:0] pd;
		bit u;
		int g;
		void'($urandom(16));
		for (int t = 0; t < 8; t++) begin
			sel = t[0];
			f = 22'($urandom);
			f.oscillator_select_fuse = sel;
			i_fuse <= f;
			i_arst_n <= 1'b0;
			repeat (12) @(posedge i_clock);
			i_arst_n <= 1'b1;
			rdt(4'h0);
			chk(rd, {31'h0, sel}, "select");
			rdt(4'h4);
			chk(rd, {30'h0, ~sel, sel}, "enables");
			wr(4'h4, 32'h0);
			rdt(4'h4);
			chk(rd, {30'h0, ~sel, sel}, "kept enable");
			wr(4'h0, {31'h0, ~sel});
			chk({30'h0, rr}, {30'h0, `RESP_OKAY}, "refused okay");
			rdt(4'h0);
			chk(rd, {31'h0, sel}, "refused select");
			rdt(4'hc);
			chk({31'h0, rd[0]}, {31'h0, sel}, "active slot");
			wr(4'h4, 32'h3);
			repeat (20) @(posedge i_clock);
			wr(4'h0, {31'h0, ~sel});
			n = cyc;
			for (int k = 0; k < 20 && (rd[0] === sel || rd[1] !== 1'b0); k++) rdt(4'hc);
			chk({31'h0, (cyc - n) <= 44}, 32'h1, "switch time");
			chk({31'h0, rd[0]}, {31'h0, ~sel}, "new slot");
			wr(4'h4, {30'h0, sel, ~sel});
			rdt(4'h4);
			chk(rd, {30'h0, sel, ~sel}, "old disabled");
			d = $urandom & 32'h000fff01;
			wr(4'h8, d);
			rdt(4'h8);
			chk(rd, d, "divider");
			rdt(4'h1);
			chk({30'h0, rr}, {30'h0, `RESP_SLVERR}, "unaligned");
			wr(4'h2, 32'h0);
			chk({30'h0, rr}, {30'h0, `RESP_SLVERR}, "unmapped write");
			$display("test %0d done", t);
		end
		// Fast-starting RC on both slots so startup and dividers can be timed
		f = 22'($urandom);
		f.primary_source = `SRC_RC;
		f.secondary_source = `SRC_RC;
		f.oscillator_select_fuse = 1'b1;
		i_fuse <= f;
		i_arst_n <= 1'b0;
		repeat (12) @(posedge i_clock);
		i_arst_n <= 1'b1;
		n = cyc;
		rdt(4'hc);
		chk({31'h0, rd[2]}, 32'h0, "early start");
		while (rd[2] !== 1'b1) rdt(4'hc);
		chk({31'h0, (cyc - n) >= `WAIT_RC}, 32'h1, "start wait");
		rl = 8'hf8 | 8'($urandom);
		pd = 4'($urandom & 3);
		u = 1'($urandom);
		wr(4'h8, {12'h0, pd, rl, 7'h0, u});
		gap(1'b0, g);
		chk(g, exp_gap(PRI_PERIOD, u, rl, 4'h0), "primary sys gap");
		gap(1'b1, g);
		chk(g, exp_gap(PRI_PERIOD, u, rl, pd), "periph gap");
		wr(4'h4, 32'h3);
		repeat (20) @(posedge i_clock);
		wr(4'h0, 32'h0);
		rdt(4'hc);
		while (rd[0] !== 1'b0 || rd[1] !== 1'b0) rdt(4'hc);
		gap(1'b0, g);
		chk(g, exp_gap(SEC_PERIOD, u, rl, 4'h0), "secondary sys gap");
		$display("test timing done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		miscompares++;
		give_verdict();
	end
endmodule // dual_oscillator_clock_select_tb_top
